// *** logic/rmc_cfg.svh ***
// Constants for the retimer misc control register bank.
// Assumes inclusion by bare name from logic/ files only.
`ifndef RMC_CFG_SVH
`define RMC_CFG_SVH

`define RMC_OFS_LANE_POWER 8'h09
`define RMC_OFS_MODE_EQ 8'h0A
`define RMC_RST_MODE_EQ 8'hB1
`define RMC_RST_LANE_POWER 8'h02
`define RMC_LP_RD_MASK 8'hDF
`define RMC_ME_RD_MASK 8'hF3
`define RMC_BIT_REORDER 7
`define RMC_BIT_INVERT 6
`define RMC_BIT_STANDBY 4
`define RMC_BIT_PWRDN 3
`define RMC_BIT_SLEEP_OFF 2
`define RMC_BIT_APP_POS 7
`define RMC_BIT_HP_BLOCK 6
`define RMC_BIT_ADAPTIVE 5
`define RMC_BIT_EQ_ON 4
`define RMC_BIT_COMMIT 2
`define RMC_RATE_5K 2'h0
`define RMC_RATE_10K 2'h1
`define RMC_RATE_100K 2'h2
`define RMC_RATE_400K 2'h3
`define RMC_MODE_REDRIVER 2'h0
`define RMC_MODE_AUTO 2'h1
`define RMC_MODE_RESERVED 2'h2
`define RMC_MODE_RETIMER 2'h3
`define RMC_RATE_HI 1
`define RMC_RATE_LO 0
`define RMC_MODE_HI 1
`define RMC_MODE_LO 0

`endif

// *** logic/rmc_pkg.sv ***
// Types for the retimer misc control register bank.
// Assumes rmc_cfg.svh supplies all numeric constants.
package rmc_pkg;
   typedef enum logic [2:0] {
      RMC_ST_RESET = 3'h1,
      RMC_ST_CAPTURE = 3'h2,
      RMC_ST_RUN = 3'h4
   } rmc_state_e;
endpackage : rmc_pkg

// *** logic/rmc_sync2.sv ***
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes inputs are static or slow relative to clk_sys.
`timescale 1ns/1ns
module rmc_sync2 #(
   parameter int WIDTH = 4
) (
   input wire logic clk_sys,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   // No reset here: pin levels keep flowing during reset, so the strap capture
   // just after release sees the real pins and not a cleared pipeline.
   always_ff @(posedge clk_sys) begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
   end
endmodule : rmc_sync2

// *** logic/rmc_regs.sv ***
// Misc control registers 09h and 0Ah of a video retimer, with decoded controls.
// Assumes a byte-wide register port from an I2C slave on clk_sys; pins are async.
//
// Contract
// - Reorder bit set swaps input lanes in redriver and retimer modes.
// - Inversion bit inverts data and clock lanes, retimer operation only.
// - Reorder and inversion load from swap strap; writes dropped in pin mode.
// - Standby bit lets receiver sleep automatically when no valid data.
// - Standby bit loads from its strap; writes ignored in pin mode.
// - Forced power down bit selects lowest power state.
// - Auto-sleep off clear lets sink hot-plug drive power down.
// - Bus rate field selects 5, 10, 100 or 400 kbps.
// - Application position bit centres adaptive equalizer for sink or source.
// - Hot-plug block bit gates sink hot-plug to source output.
// - Adaptive select chooses fixed or adaptive; writes ignored in pin mode.
// - Equalizer on bit enables equalizer; writes ignored in pin mode.
// - Equalizer settings staged; commit bit applies them and self-clears.
// - Settings apply directly while idle, powered down or clockless standby.
// - Function mode selects redriver, auto crossover, retimer; 10 reserved.
// - Reserved bits read zero and ignore writes.
`timescale 1ns/1ns
`include "rmc_cfg.svh"
module rmc_regs (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic bus_mode_strap,
   input wire logic swap_invert_strap,
   input wire logic standby_strap,
   input wire logic output_enable_pin,
   input wire logic hotplug_from_sink,
   input wire logic video_clock_present,
   input wire logic retimer_active,
   output logic hotplug_to_source,
   output logic lane_reorder,
   output logic lane_invert,
   output logic rx_standby_allowed,
   output logic power_down,
   output logic [1:0] config_bus_rate_sel,
   output logic app_pos_sink,
   output logic adaptive_eq_sel,
   output logic equalizer_on,
   output logic [1:0] function_mode_sel,
   output logic mode_reapply
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      rmc_pkg::rmc_state_e st;
      logic reorder;
      logic invert;
      logic standby;
      logic pwrdn;
      logic sleep_off;
      logic [1:0] rate;
      logic app_pos;
      logic hp_block;
      logic adaptive_stg;
      logic eq_on_stg;
      logic adaptive_act;
      logic eq_on_act;
      logic commit;
      logic [1:0] mode_stg;
      logic [1:0] mode_act;
      logic pwrdn_prev;
      logic hp_prev;
      logic [7:0] rdata;
      logic hp_out;
      logic reorder_out;
      logic invert_out;
      logic standby_out;
      logic pwr_out;
      logic reapply;
   } rmc_regs_s;

   rmc_regs_s cur_ff;
   rmc_regs_s nxt_cur;
   logic [3:0] pins_sync;
   localparam logic [7:0] ME_RST_VAL = `RMC_RST_MODE_EQ;

   rmc_sync2 #(.WIDTH(4)) u_sync (
      .clk_sys(clk_sys),
      .async_in({bus_mode_strap, swap_invert_strap, standby_strap, hotplug_from_sink}),
      .sync_out(pins_sync)
   );

   logic bus_mode;
   logic swap_pin;
   logic stby_pin;
   logic hp_sink;
   assign bus_mode = pins_sync[3];
   assign swap_pin = pins_sync[2];
   assign stby_pin = pins_sync[1];
   assign hp_sink = pins_sync[0];

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   logic wr_lp;
   logic wr_me;
   logic direct_apply;
   logic auto_sleep;
   logic [7:0] rd_lp;
   logic [7:0] rd_me;

   always_comb begin
      nxt_cur = cur_ff;
      wr_lp = reg_wr && hit(reg_addr, `RMC_OFS_LANE_POWER);
      wr_me = reg_wr && hit(reg_addr, `RMC_OFS_MODE_EQ);
      auto_sleep = !cur_ff.sleep_off && !hp_sink;
      direct_apply = !output_enable_pin || !hp_sink || cur_ff.pwrdn ||
                     (!video_clock_present && cur_ff.standby);
      rd_lp = {cur_ff.reorder, cur_ff.invert, 1'b0, cur_ff.standby, cur_ff.pwrdn,
               cur_ff.sleep_off, cur_ff.rate} & `RMC_LP_RD_MASK;
      rd_me = {cur_ff.app_pos, cur_ff.hp_block, cur_ff.adaptive_stg, cur_ff.eq_on_stg,
               2'b00, cur_ff.mode_stg} & `RMC_ME_RD_MASK;
      nxt_cur.commit = 1'b0;
      unique case (cur_ff.st)
         rmc_pkg::RMC_ST_RESET: begin
            nxt_cur.st = rmc_pkg::RMC_ST_CAPTURE;
         end
         rmc_pkg::RMC_ST_CAPTURE: begin
            // Strap capture after release; pins settle through the synchroniser.
            nxt_cur.st = rmc_pkg::RMC_ST_RUN;
            nxt_cur.reorder = swap_pin;
            nxt_cur.invert = swap_pin;
            nxt_cur.standby = stby_pin;
         end
         rmc_pkg::RMC_ST_RUN: begin
            if (wr_lp) begin
               // Swap and standby fields gated by bus mode.
               if (bus_mode) begin
                  nxt_cur.reorder = reg_wdata[`RMC_BIT_REORDER];
                  nxt_cur.invert = reg_wdata[`RMC_BIT_INVERT];
                  nxt_cur.standby = reg_wdata[`RMC_BIT_STANDBY];
               end
               nxt_cur.pwrdn = reg_wdata[`RMC_BIT_PWRDN];
               nxt_cur.sleep_off = reg_wdata[`RMC_BIT_SLEEP_OFF];
               nxt_cur.rate = reg_wdata[`RMC_RATE_HI:`RMC_RATE_LO];
            end
            if (wr_me) begin
               nxt_cur.app_pos = reg_wdata[`RMC_BIT_APP_POS];
               nxt_cur.hp_block = reg_wdata[`RMC_BIT_HP_BLOCK];
               if (bus_mode) begin
                  nxt_cur.adaptive_stg = reg_wdata[`RMC_BIT_ADAPTIVE];
                  nxt_cur.eq_on_stg = reg_wdata[`RMC_BIT_EQ_ON];
               end
               nxt_cur.commit = reg_wdata[`RMC_BIT_COMMIT];
               nxt_cur.mode_stg = reg_wdata[`RMC_MODE_HI:`RMC_MODE_LO];
            end
         end
         default: begin
            nxt_cur.st = rmc_pkg::RMC_ST_RESET;
         end
      endcase
      if (cur_ff.commit || direct_apply) begin
         nxt_cur.adaptive_act = cur_ff.adaptive_stg;
         nxt_cur.eq_on_act = cur_ff.eq_on_stg;
      end
      nxt_cur.pwrdn_prev = cur_ff.pwrdn;
      nxt_cur.hp_prev = hp_sink;
      // A level change seen while still leaving reset is not a user toggle.
      nxt_cur.reapply = (cur_ff.st == rmc_pkg::RMC_ST_RUN) &&
                        ((cur_ff.pwrdn != cur_ff.pwrdn_prev) || (hp_sink != cur_ff.hp_prev));
      if (nxt_cur.reapply) begin
         nxt_cur.mode_act = cur_ff.mode_stg;
      end
      nxt_cur.hp_out = hp_sink && !cur_ff.hp_block;
      nxt_cur.reorder_out = cur_ff.reorder;
      nxt_cur.invert_out = cur_ff.invert && retimer_active;
      nxt_cur.standby_out = cur_ff.standby;
      nxt_cur.pwr_out = cur_ff.pwrdn || auto_sleep;
      if (reg_rd && hit(reg_addr, `RMC_OFS_LANE_POWER)) begin
         nxt_cur.rdata = rd_lp;
      end else if (reg_rd && hit(reg_addr, `RMC_OFS_MODE_EQ)) begin
         nxt_cur.rdata = rd_me;
      end else if (reg_rd) begin
         nxt_cur.rdata = 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cur_ff <= '0;
         cur_ff.st <= rmc_pkg::RMC_ST_RESET;
         cur_ff.rate <= `RMC_RATE_100K;
         cur_ff.app_pos <= ME_RST_VAL[`RMC_BIT_APP_POS];
         cur_ff.adaptive_stg <= ME_RST_VAL[`RMC_BIT_ADAPTIVE];
         cur_ff.eq_on_stg <= ME_RST_VAL[`RMC_BIT_EQ_ON];
         cur_ff.adaptive_act <= ME_RST_VAL[`RMC_BIT_ADAPTIVE];
         cur_ff.eq_on_act <= ME_RST_VAL[`RMC_BIT_EQ_ON];
         cur_ff.mode_stg <= `RMC_MODE_AUTO;
         cur_ff.mode_act <= `RMC_MODE_AUTO;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign reg_rdata = cur_ff.rdata;
   assign hotplug_to_source = cur_ff.hp_out;
   assign lane_reorder = cur_ff.reorder_out;
   assign lane_invert = cur_ff.invert_out;
   assign rx_standby_allowed = cur_ff.standby_out;
   assign power_down = cur_ff.pwr_out;
   assign config_bus_rate_sel = cur_ff.rate;
   assign app_pos_sink = cur_ff.app_pos;
   assign adaptive_eq_sel = cur_ff.adaptive_act;
   assign equalizer_on = cur_ff.eq_on_act;
   assign function_mode_sel = cur_ff.mode_act;
   assign mode_reapply = cur_ff.reapply;
endmodule : rmc_regs

// *** sim/rmc_regs_sva.sv ***
// Port-level checks for the misc control register bank.
// Assumes one clk_sys domain and a synchronous active-high srst.
`timescale 1ns/1ns
module rmc_regs_sva (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic bus_mode_strap,
   input wire logic retimer_active,
   input wire logic hotplug_to_source,
   input wire logic lane_invert,
   input wire logic power_down,
   input wire logic [1:0] config_bus_rate_sel,
   input wire logic app_pos_sink,
   input wire logic adaptive_eq_sel,
   input wire logic mode_reapply
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   wire logic wr09 = reg_wr && reg_addr == 8'h09;
   wire logic wr0a = reg_wr && reg_addr == 8'h0A;
   AST_RSV_09: assert property (reg_rd && reg_addr == 8'h09 |=> !reg_rdata[5])
      else $error("reserved bit of 09h read as one");
   AST_RSV_0A: assert property (reg_rd && reg_addr == 8'h0A |=> reg_rdata[3:2] == 2'h0)
      else $error("reserved or commit bit of 0Ah read as one");
   AST_UNMAPPED: assert property (reg_rd && reg_addr != 8'h09 && reg_addr != 8'h0A
      |=> reg_rdata == 8'h00)
      else $error("unmapped offset read nonzero");
   AST_RATE: assert property (wr09 |=> config_bus_rate_sel == $past(reg_wdata[1:0]))
      else $error("bus rate field not taken from write");
   AST_PWRDN: assert property (wr09 && reg_wdata[3] |-> ##2 power_down)
      else $error("forced power down not applied");
   AST_APP_POS: assert property (wr0a |=> app_pos_sink == $past(reg_wdata[7]))
      else $error("application position not taken from write");
   AST_HP_BLOCK: assert property (wr0a && reg_wdata[6] |-> ##2 !hotplug_to_source)
      else $error("hot-plug output not blocked");
   AST_COMMIT: assert property (wr0a && reg_wdata[2] && bus_mode_strap
      |-> ##2 adaptive_eq_sel == $past(reg_wdata[5], 2))
      else $error("commit did not apply adaptive select");
   AST_INVERT: assert property (!retimer_active [*3] |-> !lane_invert)
      else $error("inversion outside retimer operation");
   AST_REAPPLY: assert property (mode_reapply |=> !mode_reapply)
      else $error("mode reapply pulse longer than one cycle");
   cover property (wr0a && reg_wdata[2]);
   cover property (mode_reapply);
   cover property ($fell(hotplug_to_source));
endmodule : rmc_regs_sva

bind rmc_regs rmc_regs_sva sva (
   .clk_sys(clk_sys),
   .srst(srst),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata),
   .bus_mode_strap(bus_mode_strap),
   .retimer_active(retimer_active),
   .hotplug_to_source(hotplug_to_source),
   .lane_invert(lane_invert),
   .power_down(power_down),
   .config_bus_rate_sel(config_bus_rate_sel),
   .app_pos_sink(app_pos_sink),
   .adaptive_eq_sel(adaptive_eq_sel),
   .mode_reapply(mode_reapply)
);

// *** sim/rmc_cfg_master.sv ***
// Register port master standing in for the configuration bus slave logic.
// Assumes the bench calls its tasks; it drives only just after rising edges.
`timescale 1ns/1ns
module rmc_cfg_master (
   input wire logic clk_sys,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // Released lines show the inverse so stale values never look valid.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      // Read data is registered and stands from the edge after the strobe.
      @(posedge clk_sys);
      d = reg_rdata;
   endtask : rd
endmodule : rmc_cfg_master

// *** sim/rmc_regs_bench.sv ***
// Self-checking bench for the misc control register bank.
// Assumes rmc_regs_sva is bound to rmc_regs and compiled alongside.
`timescale 1ns/1ns
module rmc_regs_bench;
   logic clk_sys, srst, bus_mode_strap, swap_invert_strap, standby_strap;
   logic output_enable_pin, hotplug_from_sink, video_clock_present, retimer_active;
   logic reg_wr, reg_rd, hotplug_to_source, lane_reorder, lane_invert, rx_standby_allowed;
   logic power_down, app_pos_sink, adaptive_eq_sel, equalizer_on, mode_reapply;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
   logic [1:0] config_bus_rate_sel, function_mode_sel;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;
   int reapply_seen = 0;
   int reapply_base = 0;
   // Each row is offset, write byte, expected read-back.
   logic [23:0] rows [10] = '{24'h090404, 24'h09FFDF, 24'h090101, 24'h090202, 24'h090000,
      24'h0AFFF3, 24'h0A3131, 24'h0AB0B0, 24'h0AB1B1, 24'h05FF00};
   wire logic [7:0] st = {lane_reorder, lane_invert, rx_standby_allowed, power_down,
      hotplug_to_source, app_pos_sink, adaptive_eq_sel, equalizer_on};
   wire logic [7:0] md = {4'h0, config_bus_rate_sel, function_mode_sel};
   rmc_regs uut (
      .clk_sys(clk_sys),
      .srst(srst),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .bus_mode_strap(bus_mode_strap),
      .swap_invert_strap(swap_invert_strap),
      .standby_strap(standby_strap),
      .output_enable_pin(output_enable_pin),
      .hotplug_from_sink(hotplug_from_sink),
      .video_clock_present(video_clock_present),
      .retimer_active(retimer_active),
      .hotplug_to_source(hotplug_to_source),
      .lane_reorder(lane_reorder),
      .lane_invert(lane_invert),
      .rx_standby_allowed(rx_standby_allowed),
      .power_down(power_down),
      .config_bus_rate_sel(config_bus_rate_sel),
      .app_pos_sink(app_pos_sink),
      .adaptive_eq_sel(adaptive_eq_sel),
      .equalizer_on(equalizer_on),
      .function_mode_sel(function_mode_sel),
      .mode_reapply(mode_reapply)
   );
   rmc_cfg_master m (
      .clk_sys(clk_sys),
      .reg_rdata(reg_rdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata)
   );
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      m.rd(a, rd_val);
      chk(rd_val, exp);
   endtask : rdchk
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick
   task automatic conclude();
      if (miscompares == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (mode_reapply === 1'b1) reapply_seen <= reapply_seen + 1;
      if (cycles == 2000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      srst = 1'b1;
      bus_mode_strap = 1'b1;
      swap_invert_strap = 1'b1;
      standby_strap = 1'b1;
      output_enable_pin = 1'b1;
      hotplug_from_sink = 1'b1;
      video_clock_present = 1'b1;
      retimer_active = 1'b0;
      tick(10);
      srst <= 1'b0;
      tick(6);
      rdchk(8'h09, 8'hD2);
      rdchk(8'h0A, 8'hB1);
      chk(st, 8'hAF);
      chk(md, 8'h09);
      chk(8'(reapply_seen), 8'h00);
      @(posedge clk_sys) retimer_active <= 1'b1;
      tick(3);
      chk(st, 8'hEF);
      @(posedge clk_sys) bus_mode_strap <= 1'b0;
      tick(4);
      m.wr(8'h09, 8'h00);
      rdchk(8'h09, 8'hD0);
      m.wr(8'h0A, 8'h04);
      rdchk(8'h0A, 8'h30);
      tick(2);
      chk(st, 8'hEB);
      @(posedge clk_sys) bus_mode_strap <= 1'b1;
      tick(4);
      foreach (rows[i]) begin
         m.wr(rows[i][23:16], rows[i][15:8]);
         rdchk(rows[i][23:16], rows[i][7:0]);
      end
      // ----------------------------------------------------------------
      // Directed cases
      // ----------------------------------------------------------------
      m.wr(8'h0A, 8'h33);
      tick(3);
      chk(md, 8'h00);
      reapply_base = reapply_seen;
      m.wr(8'h09, 8'h08);
      m.wr(8'h09, 8'h00);
      tick(3);
      chk(md, 8'h03);
      chk(8'(reapply_seen - reapply_base), 8'h02);
      m.wr(8'h0A, 8'h01);
      tick(3);
      chk(st, 8'h0B);
      m.wr(8'h0A, 8'h05);
      tick(3);
      chk(st, 8'h08);
      @(posedge clk_sys) output_enable_pin <= 1'b0;
      m.wr(8'h0A, 8'h31);
      tick(3);
      chk(st, 8'h0B);
      @(posedge clk_sys) output_enable_pin <= 1'b1;
      hotplug_from_sink <= 1'b0;
      tick(5);
      chk(st, 8'h13);
      m.wr(8'h09, 8'h04);
      tick(3);
      chk(st, 8'h03);
      @(posedge clk_sys) hotplug_from_sink <= 1'b1;
      tick(5);
      chk(st, 8'h0B);
      m.wr(8'h0A, 8'h71);
      tick(3);
      chk(st, 8'h03);
      m.wr(8'h09, 8'h0C);
      tick(3);
      chk(st, 8'h13);
      m.wr(8'h09, 8'h14);
      @(posedge clk_sys) video_clock_present <= 1'b0;
      m.wr(8'h0A, 8'h01);
      tick(3);
      chk(st, 8'h28);
      reapply_base = reapply_seen;
      @(posedge clk_sys) srst <= 1'b1;
      swap_invert_strap <= 1'b0;
      standby_strap <= 1'b0;
      video_clock_present <= 1'b1;
      tick(4);
      srst <= 1'b0;
      tick(6);
      rdchk(8'h09, 8'h02);
      rdchk(8'h0A, 8'hB1);
      chk(st, 8'h0F);
      chk(md, 8'h09);
      chk(8'(reapply_seen - reapply_base), 8'h00);
      conclude();
   end
endmodule : rmc_regs_bench
